// ---- shared/scad_pkg.sv ----
// scad_pkg: frame layout, command codes and decode encodings for the command decoder
// assumes a 29-bit frame already shifted in and presented with a load strobe
package scad_pkg;
  localparam int unsigned FRAME_W   = 29;
  localparam int unsigned DATA_W    = 22;
  localparam int unsigned CHAN_N    = 4;
  localparam int unsigned RW_POS    = 28;
  localparam int unsigned CHSEL_HI  = 27;
  localparam int unsigned CHSEL_LO  = 24;
  localparam int unsigned GRP_HI    = 23;
  localparam int unsigned GRP_LO    = 22;
  localparam logic [1:0] GRP_FUNC   = 2'h0;
  localparam logic [1:0] GRP_GAIN   = 2'h1;
  localparam logic [1:0] GRP_OFFS   = 2'h2;
  localparam logic [1:0] GRP_LEVEL  = 2'h3;
  localparam logic [21:0] DATA_ONES = 22'h3fffff;
  localparam logic [21:0] DATA_ZERO = 22'h000000;
  // readback source select
  typedef enum logic [2:0] {
    SCAD_RB_NONE  = 3'h0,
    SCAD_RB_CTRL  = 3'h1,
    SCAD_RB_CMP   = 3'h2,
    SCAD_RB_ALARM = 3'h3,
    SCAD_RB_CHAN  = 3'h4
  } scad_rb_e;
  // decoded command class
  typedef enum logic [2:0] {
    SCAD_CMD_NONE  = 3'h0,
    SCAD_CMD_CTRL  = 3'h1,
    SCAD_CMD_CHWR  = 3'h2,
    SCAD_CMD_IDLE  = 3'h3,
    SCAD_CMD_READ  = 3'h4,
    SCAD_CMD_RESV  = 3'h5
  } scad_cmd_e;
endpackage

// ---- rtl/scad_onehot.sv ----
// scad_onehot: checks that a channel select field has exactly one bit set
// purely combinational, no clock
`timescale 1ns/10ps
`default_nettype none
module scad_onehot #(
  parameter int unsigned N = 4
) (
  input  wire logic [N-1:0] SEL_IN,
  output logic              ONE_OUT,
  output logic [1:0]        IDX_OUT
);
  // ----------------------------------------
  // population count and index
  // ----------------------------------------
  function automatic logic [2:0] pop(input logic [N-1:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < N; i++) begin
      c = c + {2'h0, v[i]};
    end
    return c;
  endfunction
  function automatic logic [1:0] idx(input logic [N-1:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < N; i++) begin
      if (v[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction
  assign ONE_OUT = (pop(SEL_IN) == 3'h1);
  assign IDX_OUT = idx(SEL_IN);
endmodule
`default_nettype wire

// ---- rtl/scad_decoder.sv ----
// scad_decoder: decodes a 29-bit serial command frame into register actions
// assumes FRAME_IN is stable while LOAD_IN pulses for one cycle at frame end
// Functional notes
// RULE_01 - frame is 29 bits; top seven bits are flag, channels, group
// RULE_02 - group 00 control/function, 01 gain, 10 offset, 11 level input
// RULE_03 - top bit high starts readback, low means write
// RULE_04 - readback source chosen by address: function, alarm, comparator, control, level
// RULE_05 - channel select bits map channel three high down to zero
// RULE_06 - nonzero select writes same group and data to every selected channel
// RULE_07 - all-zero select and group write loads device control register
// RULE_08 - zero select, group 11, all-ones data is idle, changes nothing
// RULE_09 - host may send idle command while shifting out readback data
// RULE_10 - host avoids reserved zero-select writes of groups 01, 10, 11
// RULE_11 - host never sends unassigned codes
// RULE_12 - zero-select read: 00 control, 01 comparator, 11 alarm, 10 reserved
// RULE_13 - per-channel read sets exactly one channel select bit
// RULE_14 - host fills data with zeros or level address plus zeros on reads
// RULE_15 - unassigned frames flag reserved and update nothing
`timescale 1ns/10ps
`default_nettype none
module scad_decoder #(
  parameter int unsigned CHAN_N = scad_pkg::CHAN_N
) (
  input  wire logic        MCLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        LOAD_IN,
  input  wire logic [28:0] FRAME_IN,
  output logic             CTRL_WE_OUT,
  output logic [3:0]       CHAN_WE_OUT,
  output logic [1:0]       GROUP_OUT,
  output logic [21:0]      DATA_OUT,
  output logic             READ_OUT,
  output logic [2:0]       RB_SRC_OUT,
  output logic [1:0]       RB_CHAN_OUT,
  output logic             IDLE_OUT,
  output logic             RESERVED_OUT
);
  // ----------------------------------------
  // field split
  // ----------------------------------------
  // RULE_01 - field split
  wire        rw_bit   = FRAME_IN[scad_pkg::RW_POS];
  // RULE_05 - channel bit order
  wire [3:0]  chsel    = FRAME_IN[scad_pkg::CHSEL_HI:scad_pkg::CHSEL_LO];
  // RULE_02 - register group field
  wire [1:0]  grp      = FRAME_IN[scad_pkg::GRP_HI:scad_pkg::GRP_LO];
  wire [21:0] data     = FRAME_IN[scad_pkg::DATA_W-1:0];
  wire        sel_zero = (chsel == 4'h0);
  wire        one_hot;
  wire [1:0]  one_idx;

  // highest set bit wins the index; reads refuse non-one-hot selects anyway
  scad_onehot #(.N(CHAN_N)) u_onehot (
    .SEL_IN  (chsel),
    .ONE_OUT (one_hot),
    .IDX_OUT (one_idx)
  );

  // ----------------------------------------
  // command classification
  // ----------------------------------------
  // RULE_03 - read versus write
  wire is_wr   = ~rw_bit;
  // RULE_07 - device control write
  wire ctrl_wr = is_wr & sel_zero & (grp == scad_pkg::GRP_FUNC);
  // RULE_08 - idle command
  wire idle_wr = is_wr & sel_zero & (grp == scad_pkg::GRP_LEVEL) & (data == scad_pkg::DATA_ONES);
  // RULE_06 - multichannel write
  wire chan_wr = is_wr & ~sel_zero;
  // RULE_12 - global readback select
  wire rd_ctrl = rw_bit & sel_zero & (grp == scad_pkg::GRP_FUNC);
  wire rd_cmp  = rw_bit & sel_zero & (grp == scad_pkg::GRP_GAIN);
  wire rd_alm  = rw_bit & sel_zero & (grp == scad_pkg::GRP_LEVEL);
  // RULE_13 - single channel readback only
  wire rd_chan = rw_bit & one_hot;
  wire rd_any  = rd_ctrl | rd_cmp | rd_alm | rd_chan;
  // RULE_15 - everything else is reserved
  wire resv    = ~(ctrl_wr | idle_wr | chan_wr | rd_any);

  // RULE_04 - readback source
  wire [2:0] rb_src = rd_ctrl ? scad_pkg::SCAD_RB_CTRL :
                      rd_cmp  ? scad_pkg::SCAD_RB_CMP  :
                      rd_alm  ? scad_pkg::SCAD_RB_ALARM :
                      rd_chan ? scad_pkg::SCAD_RB_CHAN : scad_pkg::SCAD_RB_NONE;

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  logic        ctrl_we_q;
  logic [3:0]  chan_we_q;
  logic [1:0]  grp_q;
  logic [21:0] data_q;
  logic        read_q;
  logic [2:0]  rb_src_q;
  logic [1:0]  rb_chan_q;
  logic        idle_q;
  logic        resv_q;

  // strobes last one cycle; data holds until the next frame
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ctrl_we_q <= 1'b0;
      chan_we_q <= 4'h0;
      read_q    <= 1'b0;
      idle_q    <= 1'b0;
      resv_q    <= 1'b0;
    end else begin
      ctrl_we_q <= LOAD_IN & ctrl_wr;
      // RULE_06 - fan write to selected channels
      chan_we_q <= (LOAD_IN & chan_wr) ? chsel : 4'h0;
      read_q    <= LOAD_IN & rd_any;
      idle_q    <= LOAD_IN & idle_wr;
      resv_q    <= LOAD_IN & resv;
    end
  end

  // reserved frames still load these; only the strobes are gated
  always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      grp_q     <= 2'h0;
      data_q    <= 22'h000000;
      rb_src_q  <= 3'h0;
      rb_chan_q <= 2'h0;
    end else if (LOAD_IN) begin
      grp_q     <= grp;
      data_q    <= data;
      rb_src_q  <= rb_src;
      rb_chan_q <= one_idx;
    end
  end

  assign CTRL_WE_OUT  = ctrl_we_q;
  assign CHAN_WE_OUT  = chan_we_q;
  assign GROUP_OUT    = grp_q;
  assign DATA_OUT     = data_q;
  assign READ_OUT     = read_q;
  assign RB_SRC_OUT   = rb_src_q;
  assign RB_CHAN_OUT  = rb_chan_q;
  assign IDLE_OUT     = idle_q;
  assign RESERVED_OUT = resv_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // strobe checks look one edge after the load that caused them

  read_flag_a: assert property (LOAD_IN && rw_bit && !resv |=> // RULE_03
    READ_OUT && CHAN_WE_OUT == 4'h0 && !CTRL_WE_OUT)
    else $error("read frame did not start readback");
  chan_fan_a: assert property (LOAD_IN && !rw_bit && chsel != 4'h0 |=> // RULE_06
    CHAN_WE_OUT == $past(chsel) && GROUP_OUT == $past(grp))
    else $error("channel write fan-out wrong");
  chan_data_a: assert property (LOAD_IN && !rw_bit && chsel != 4'h0 |=> // RULE_06
    DATA_OUT == $past(data) && !CTRL_WE_OUT && !READ_OUT)
    else $error("channel write data not passed");
  chan_order_a: assert property (LOAD_IN && !rw_bit && FRAME_IN[27:24] == 4'h8 |=> // RULE_05
    CHAN_WE_OUT[3] && !CHAN_WE_OUT[0])
    else $error("channel bit order wrong");
  chan_low_a: assert property (LOAD_IN && FRAME_IN[28:24] == 5'h11 |=> // RULE_05
    RB_SRC_OUT == 3'h4 && RB_CHAN_OUT == 2'h0)
    else $error("channel zero readback index wrong");
  ctrl_write_a: assert property (LOAD_IN && FRAME_IN[28:22] == 7'h00 |=> // RULE_07
    CTRL_WE_OUT && DATA_OUT == $past(data))
    else $error("control write missed");
  idle_cmd_a: assert property (LOAD_IN && FRAME_IN[28:22] == 7'h03 && &data |=> // RULE_08
    IDLE_OUT && !CTRL_WE_OUT && CHAN_WE_OUT == 4'h0)
    else $error("idle command changed a register");
  idle_resv_a: assert property (LOAD_IN && FRAME_IN[28:22] == 7'h03 && !(&data) |=> // RULE_08
    RESERVED_OUT && !IDLE_OUT)
    else $error("partial idle code not refused");
  resv_quiet_a: assert property (RESERVED_OUT |-> // RULE_15
    !CTRL_WE_OUT && CHAN_WE_OUT == 4'h0 && !READ_OUT && !IDLE_OUT)
    else $error("reserved frame caused an action");
  resv_write_a: assert property (LOAD_IN && FRAME_IN[28:24] == 5'h00 && // RULE_15
    grp[1] != grp[0] |=> RESERVED_OUT && !CTRL_WE_OUT && !IDLE_OUT)
    else $error("reserved global write not refused");
  one_answer_a: assert property (LOAD_IN |=> // RULE_15
    $onehot({CTRL_WE_OUT, |CHAN_WE_OUT, READ_OUT, IDLE_OUT, RESERVED_OUT}))
    else $error("frame did not give exactly one answer");
  quiet_gap_a: assert property (!LOAD_IN |=> // RULE_15
    CHAN_WE_OUT == 4'h0 && !CTRL_WE_OUT && !READ_OUT && !IDLE_OUT && !RESERVED_OUT)
    else $error("strobe without a frame");
  glob_read_a: assert property (LOAD_IN && FRAME_IN[28:22] == 7'h41 |=> // RULE_12
    READ_OUT && RB_SRC_OUT == 3'h2)
    else $error("comparator readback not selected");
  ctrl_read_a: assert property (LOAD_IN && FRAME_IN[28:22] == 7'h40 |=> // RULE_12
    READ_OUT && RB_SRC_OUT == 3'h1)
    else $error("control readback not selected");
  alarm_read_a: assert property (LOAD_IN && FRAME_IN[28:22] == 7'h43 |=> // RULE_12
    READ_OUT && RB_SRC_OUT == 3'h3)
    else $error("alarm readback not selected");
  resv_read_a: assert property (LOAD_IN && FRAME_IN[28:22] == 7'h42 |=> // RULE_12
    RESERVED_OUT && !READ_OUT && RB_SRC_OUT == 3'h0)
    else $error("reserved global read not refused");
  rb_source_a: assert property (LOAD_IN && rw_bit && FRAME_IN[27:24] == 4'h4 |=> // RULE_04
    RB_SRC_OUT == 3'h4 && RB_CHAN_OUT == 2'h2)
    else $error("channel readback source wrong");
  write_src_a: assert property (LOAD_IN && !rw_bit |=> // RULE_04
    RB_SRC_OUT == 3'h0 && !READ_OUT)
    else $error("write frame selected a readback source");
  held_fields_a: assert property (!LOAD_IN |=> // RULE_04
    $stable(DATA_OUT) && $stable(GROUP_OUT) && $stable(RB_SRC_OUT) && $stable(RB_CHAN_OUT))
    else $error("held fields moved without a frame");
  multi_read_a: assert property (LOAD_IN && rw_bit && FRAME_IN[27:24] == 4'h3 |=> // RULE_13
    RESERVED_OUT && !READ_OUT)
    else $error("multichannel read not reserved");
  group_pass_a: assert property (LOAD_IN && !rw_bit && chsel != 4'h0 ##1 1'b1 |-> // RULE_02
    GROUP_OUT == $past(FRAME_IN[23:22]))
    else $error("group field not passed");
  frame_split_a: assert property (LOAD_IN |=> // RULE_01
    DATA_OUT == $past(FRAME_IN[21:0]))
    else $error("data field split wrong");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  cov_ctrl_c: cover property (CTRL_WE_OUT);
  cov_all_c:  cover property (CHAN_WE_OUT == 4'hf);
  cov_idle_c: cover property (IDLE_OUT);
  cov_read_c: cover property (READ_OUT && RB_SRC_OUT == 3'h4);
  cov_resv_c: cover property (RESERVED_OUT);
endmodule
`default_nettype wire

// ---- tb/scad_host.sv ----
// scad_host: host model that launches command frames into the decoder
// assumes a free-running clock; every change lands just after a falling edge
`timescale 1ns/10ps
`default_nettype none
module scad_host (
  input  wire logic   clk_in,
  output logic        load_out,
  output logic [28:0] frame_out
);
  // frame launch
  // send does not filter frames; reserved codes go out whenever the bench passes one
  task automatic send(input logic [28:0] f);
    @(negedge clk_in);
    load_out  <= 1'b1;
    frame_out <= f;
  endtask
  // bus released: inverse of the current bus value, so stale data cannot match except after two rests in a row
  task automatic rest();
    @(negedge clk_in);
    load_out  <= 1'b0;
    frame_out <= ~frame_out;
  endtask
  initial begin
    load_out  = 1'b0;
    frame_out = 29'h0;
  end
endmodule
`default_nettype wire

// ---- tb/serial_command_address_decoder_tb.sv ----
// serial_command_address_decoder_tb: code sweep plus random frames against the decoder
// assumes one clock; host model drives, outputs checked one cycle after each load
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  n_compared++; \
  if ((g) !== (e)) begin err_count++; $display("ERROR %s expected %h seen %h", nm, e, g); end
module serial_command_address_decoder_tb;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        load;
  logic [28:0] frame;
  logic        ctrl_we;
  logic [3:0]  chan_we;
  logic [1:0]  grp;
  logic [21:0] data;
  logic        rd;
  logic [2:0]  rb_src;
  logic [1:0]  rb_chan;
  logic        idl;
  logic        resv;
  wire  [7:0]  strb = {ctrl_we, chan_we, rd, idl, resv};
  logic [2:0]  hsrc = 3'h0;
  logic [12:0] e;
  logic [28:0] held = 29'h0;
  logic [28:0] f;
  logic [31:0] d;
  integer      seed = 32'hfcc1;
  int          err_count = 0;
  int          n_compared = 0;
  always #25 mclk = ~mclk;
  scad_host u_host (.clk_in(mclk), .load_out(load), .frame_out(frame));
  scad_decoder DUT (
    .MCLK_IN(mclk), .RSTN_IN(rstn), .LOAD_IN(load), .FRAME_IN(frame),
    .CTRL_WE_OUT(ctrl_we), .CHAN_WE_OUT(chan_we), .GROUP_OUT(grp), .DATA_OUT(data),
    .READ_OUT(rd), .RB_SRC_OUT(rb_src), .RB_CHAN_OUT(rb_chan), .IDLE_OUT(idl),
    .RESERVED_OUT(resv));
  // ----------------------------------------
  // expectation: {ctrl, chan[3:0], read, idle, resv, src[2:0], idx[1:0]}
  // ----------------------------------------
  function automatic logic [12:0] expect_of(input logic [28:0] f);
    logic [3:0] s;
    logic [1:0] g;
    logic [12:0] r;
    s = f[27:24];
    g = f[23:22];
    r = 13'h0;
    if (!f[28] && s != 4'h0) r[11:8] = s;
    else if (!f[28] && g == scad_pkg::GRP_FUNC) r[12] = 1'b1;
    else if (!f[28] && g == scad_pkg::GRP_LEVEL && f[21:0] == scad_pkg::DATA_ONES) r[6] = 1'b1;
    else if (!f[28]) r[5] = 1'b1;
    else if (s == 4'h0 && g != scad_pkg::GRP_OFFS) begin
      r[7] = 1'b1;
      r[4:2] = (g == scad_pkg::GRP_FUNC) ? scad_pkg::SCAD_RB_CTRL :
               (g == scad_pkg::GRP_GAIN) ? scad_pkg::SCAD_RB_CMP : scad_pkg::SCAD_RB_ALARM;
    end else if (s != 4'h0 && (s & (s - 4'h1)) == 4'h0) begin
      r[7] = 1'b1;
      r[4:2] = scad_pkg::SCAD_RB_CHAN;
      r[1:0] = s[3] ? 2'h3 : s[2] ? 2'h2 : s[1] ? 2'h1 : 2'h0;
    end else r[5] = 1'b1;
    return r;
  endfunction
  // ----------------------------------------
  // checks: host updates land after this edge, so load/frame are the taken ones
  // ----------------------------------------
  always @(negedge mclk) begin
    if (!rstn) begin
      held = 29'h0;
      hsrc = 3'h0;
      `CHK("reset", 37'h0, {strb, grp, data, rb_src, rb_chan})
    end else if (load) begin
      e = expect_of(frame);
      held = frame;
      hsrc = e[4:2];
      `CHK("strobes", e[12:5], strb)
      if (e[4:2] == scad_pkg::SCAD_RB_CHAN) begin
        `CHK("rb_chan", e[1:0], rb_chan)
      end
    end else begin
      `CHK("strobes", 8'h0, strb)
    end
    if (rstn) begin
      `CHK("rb_src", hsrc, rb_src)
      `CHK("group", held[23:22], grp)
      `CHK("data", held[21:0], data)
    end
  end
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (5) @(negedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 128; i++) begin
      d = $random(seed);
      f = {i[6:0], i[6] ? 22'h0 : d[21:0]};
      u_host.send(f);
    end
    u_host.send({7'h03, scad_pkg::DATA_ONES});
    u_host.send(29'h0000055);
    u_host.rest();
    // mid-run reset: held fields must clear and decoding must resume
    rstn <= 1'b0;
    repeat (2) @(negedge mclk);
    rstn <= 1'b1;
    $display("test code_sweep done");
    repeat (300) begin
      d = $random(seed);
      f = d[28:0];
      if (f[28]) f[21:0] = 22'h0;
      if (d[30:29] == 2'h0) f = {7'h03, scad_pkg::DATA_ONES};
      u_host.send(f);
      if (d[31]) u_host.rest();
    end
    u_host.rest();
    u_host.rest();
    $display("test random_mix done");
    finish_test();
  end
endmodule
`default_nettype wire
